// File: core/recovery_timer.sv
// Hardware recovery timer with prescaler and reset-out pulse
//
// Functional notes
// - Disabled and silent after every reset.
// - Writing 1E then E1 enables it.
// - Counts one per machine cycle when running.
// - Software cannot stop it once enabled.
// - Overflow drives high reset pulse out.
// - Same key pair restarts the count.
// - Base counter 14 bits, tops at 3FFF.
// - Service register write-only, counter hidden.
// - Reset pulse lasts 96 peripheral clocks.
// - Seven-bit prescaler extends the time-out.
// - Code n gives 2^(14+n) cycles.
// - Select field resets to 000.
// - Halts while oscillator stopped in power-down.
// - Waits for wake interrupt release.
// - Keeps counting in idle mode.
`timescale 1ns/10ps
module recovery_timer (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // Special-function register access
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   output logic [7:0] o_sfr_rdata,
   // Power management
   input wire logic i_power_down,
   input wire logic i_idle,
   input wire logic i_wake_int_n,
   // Reset pin drive
   output logic o_rst_out,
   output logic o_rst_oe,
   // Status
   output logic o_running,
   output logic [recovery_timer_pkg::SEL_W-1:0] o_timeout_sel
);
   import recovery_timer_pkg::*;

   // ===========================================================
   // State
   typedef struct packed {
      wd_state_t state;
      logic [BASE_W-1:0] base;
      logic [PRESC_W-1:0] presc;
      logic [SEL_W-1:0] sel;
      logic pd_hold;
      logic [PULSE_W-1:0] pulse_cnt;
      logic rst_out;
      logic rst_oe;
      logic running;
      logic [7:0] rdata;
   } top_state_t;

   localparam top_state_t ST_RESET = '{
      state: ST_OFF,
      base: BASE_ZERO,
      presc: PRESC_ZERO,
      sel: SEL_RESET,
      pd_hold: 1'b0,
      pulse_cnt: PULSE_ZERO,
      rst_out: 1'b0,
      rst_oe: 1'b0,
      running: 1'b0,
      rdata: READ_ZERO
   };

   top_state_t st_q;
   top_state_t st_d;

   logic mc_tick;
   logic key_done;
   logic key_wr;
   logic sel_wr;
   logic halted;
   logic count_en;
   logic [PRESC_W-1:0] presc_mask;
   logic carry;
   logic overflow;
   logic div_run;
   logic div_clear;

   // ===========================================================
   // Decode and counting terms
   // Service writes during the reset pulse are dropped; the core is being reset
   assign key_wr = i_sfr_wr && (i_sfr_addr == SERVICE_ADDR)
                   && (st_q.state != ST_PULSE);
   assign sel_wr = i_sfr_wr && (i_sfr_addr == TIMEOUT_ADDR);

   // Oscillator stopped, or still waiting for the wake pin to rise
   assign halted = i_power_down || st_q.pd_hold;
   // Idle leaves the oscillator running, so idle never gates here
   assign count_en = mc_tick && !halted;

   // Low n prescaler bits form the extension for code n
   assign presc_mask = PRESC_FULL >> (SEL_MAX - st_q.sel);
   assign carry = ((st_q.presc & presc_mask) == presc_mask);
   assign overflow = (st_q.state == ST_RUN) && count_en && carry
                     && (st_q.base == BASE_TOP);

   assign div_run = (st_q.state == ST_RUN) && !halted;
   assign div_clear = key_done || (st_q.state != ST_RUN);

   // ===========================================================
   // Helpers
   mc_tick_divider #(
      .DIV(MACHINE_CYCLE_CLOCKS)
   ) u_div (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_run(div_run),
      .i_clear(div_clear),
      .o_tick(mc_tick)
   );

   key_sequence_detector u_keys (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_wr(key_wr),
      .i_data(i_sfr_wdata),
      .o_done(key_done)
   );

   // ===========================================================
   // Next-state logic
   always_comb begin
      st_d = st_q;

      // Power-down wake hold: released only by the wake pin going high
      if (i_power_down) begin
         st_d.pd_hold = 1'b1;
      end else if (i_wake_int_n) begin
         st_d.pd_hold = 1'b0;
      end

      // Time-out select; reserved upper bits are not stored
      if (sel_wr) begin
         st_d.sel = i_sfr_wdata[SEL_LSB +: SEL_W];
      end

      // Read data, one cycle after the strobe; counter never visible
      st_d.rdata = READ_ZERO;
      if (i_sfr_rd) begin
         if (i_sfr_addr == TIMEOUT_ADDR) begin
            st_d.rdata = {RSVD_READ, st_q.sel};
         end else if (i_sfr_addr == SERVICE_ADDR) begin
            st_d.rdata = READ_ZERO;
         end else begin
            st_d.rdata = READ_ZERO;
         end
      end

      case (st_q.state)
         ST_OFF: begin
            // Nothing counts until the key pair arrives
            st_d.base = BASE_ZERO;
            st_d.presc = PRESC_ZERO;
            if (key_done) begin
               st_d.state = ST_RUN;
            end
         end
         ST_RUN: begin
            // No software path leads back to off
            if (overflow) begin
               st_d.state = ST_PULSE;
               st_d.pulse_cnt = PULSE_ZERO;
               st_d.rst_out = 1'b1;
               st_d.rst_oe = 1'b1;
            end else if (key_done) begin
               st_d.base = BASE_ZERO;
               st_d.presc = PRESC_ZERO;
            end else if (count_en) begin
               st_d.presc = st_q.presc + PRESC_ONE;
               if (carry) begin
                  st_d.base = st_q.base + BASE_ONE;
               end
            end
         end
         ST_PULSE: begin
            // Fixed-length pulse, then everything but the wake hold back to reset values
            if (st_q.pulse_cnt == PULSE_LAST) begin
               st_d = ST_RESET;
               st_d.pd_hold = st_q.pd_hold;
            end else begin
               st_d.pulse_cnt = st_q.pulse_cnt + PULSE_ONE;
            end
         end
         default: begin
            st_d = ST_RESET;
         end
      endcase

      st_d.running = (st_d.state == ST_RUN);
   end

   // ===========================================================
   // State register
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         st_q <= ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flops
   assign o_sfr_rdata = st_q.rdata;
   assign o_rst_out = st_q.rst_out;
   assign o_rst_oe = st_q.rst_oe;
   assign o_running = st_q.running;
   assign o_timeout_sel = st_q.sel;

   // ===========================================================
   // Checks
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_off;
      st_q.state == ST_OFF;
   endsequence

   sequence s_running_key;
      (st_q.state == ST_RUN) && key_done && !overflow;
   endsequence

   sequence s_frozen_step;
      (st_q.state == ST_RUN) && halted && !key_done;
   endsequence

   AST_OFF_SILENT: assert property (
      s_off ##0 !key_done |=> (st_q.state == ST_OFF) && !o_rst_out
      && (st_q.base == BASE_ZERO) && !o_running)
      else $error("watchdog active without key pair");

   AST_KEY_ENABLES: assert property (
      s_off ##0 key_done |=> o_running ##1 o_running)
      else $error("key pair did not enable watchdog");

   AST_STEP: assert property (
      (st_q.state == ST_RUN) && count_en && !overflow && !key_done
      |=> st_q.presc == $past(st_q.presc) + PRESC_ONE)
      else $error("prescaler missed a machine cycle");

   // Idle must not gate the count; a tick in idle still steps
   AST_IDLE_COUNTS: assert property (
      (st_q.state == ST_RUN) && i_idle && count_en && !overflow
      && !key_done |=> st_q.presc != $past(st_q.presc))
      else $error("count stalled in idle mode");

   AST_NO_STOP: assert property (
      st_q.state == ST_RUN |=> st_q.state != ST_OFF)
      else $error("running watchdog was stopped");

   AST_OVF_PULSE: assert property (
      overflow |=> o_rst_out && o_rst_oe)
      else $error("overflow gave no reset pulse");

   AST_SERVICE_CLEAR: assert property (
      s_running_key |=> (st_q.base == BASE_ZERO)
      && (st_q.presc == PRESC_ZERO) && o_running)
      else $error("service did not restart the count");

   AST_OVF_POINT: assert property (
      overflow |-> (st_q.base == BASE_TOP) && carry)
      else $error("overflow at wrong count");

   AST_PULSE_END: assert property (
      $fell(o_rst_out) |-> $past(st_q.pulse_cnt) == PULSE_LAST)
      else $error("reset pulse length wrong");

   AST_PULSE_START: assert property (
      $rose(o_rst_out) |-> st_q.pulse_cnt == PULSE_ZERO ##1 o_rst_out)
      else $error("reset pulse started wrongly");

   AST_SEL_RESET: assert property (
      $rose(i_nrst) |-> o_timeout_sel == SEL_RESET)
      else $error("select field not cleared by reset");

   AST_HALT: assert property (
      s_frozen_step |=> $stable(st_q.base) && $stable(st_q.presc))
      else $error("counter moved while halted");

   AST_WAKE_WAIT: assert property (
      !i_power_down && st_q.pd_hold && !i_wake_int_n |=> st_q.pd_hold)
      else $error("resumed before wake pin rose");

   AST_HIDDEN: assert property (
      i_sfr_rd && (i_sfr_addr == SERVICE_ADDR) |=> o_sfr_rdata == READ_ZERO)
      else $error("service register read back data");

endmodule : recovery_timer

// File: shared/recovery_timer_pkg.sv
// Constants and types shared by the recovery timer files
package recovery_timer_pkg;

   // ===========================================================
   // Special-function register map and key bytes
   localparam logic [7:0] SERVICE_ADDR = 8'ha6;
   localparam logic [7:0] TIMEOUT_ADDR = 8'ha7;
   localparam logic [7:0] KEY_FIRST = 8'he1 ^ 8'hff;
   localparam logic [7:0] KEY_SECOND = 8'he1;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ===========================================================
   // Field layout and reset values
   localparam int BASE_W = 14;
   localparam int PRESC_W = 7;
   localparam int SEL_W = 3;
   localparam int SEL_LSB = 0;
   localparam int RSVD_W = 8 - SEL_W;
   localparam logic [BASE_W-1:0] BASE_TOP = 14'h3fff;
   localparam logic [BASE_W-1:0] BASE_ZERO = 14'h0000;
   localparam logic [PRESC_W-1:0] PRESC_ZERO = 7'h00;
   localparam logic [PRESC_W-1:0] PRESC_FULL = 7'h7f;
   localparam logic [PRESC_W-1:0] PRESC_ONE = 7'h01;
   localparam logic [BASE_W-1:0] BASE_ONE = 14'h0001;
   localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
   localparam logic [SEL_W-1:0] SEL_MAX = 3'h7;
   localparam logic [RSVD_W-1:0] RSVD_READ = 5'h00;

   // ===========================================================
   // Timing
   localparam int SYS_CLK_PERIOD_NS = 25;
   localparam int MACHINE_CYCLE_CLOCKS = 6;
   localparam int PERIPH_CLK_PERIOD_NS = 25;
   localparam int PULSE_PERIODS = 96;
   localparam int PULSE_CYCLES =
      (PULSE_PERIODS * PERIPH_CLK_PERIOD_NS + SYS_CLK_PERIOD_NS - 1)
      / SYS_CLK_PERIOD_NS;
   localparam int PULSE_W = 7;
   localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(PULSE_CYCLES - 1);
   localparam logic [PULSE_W-1:0] PULSE_ZERO = 7'h00;
   localparam logic [PULSE_W-1:0] PULSE_ONE = 7'h01;

   // ===========================================================
   // Watchdog states, one-hot
   typedef enum logic [2:0] {
      ST_OFF   = 3'b001,
      ST_RUN   = 3'b010,
      ST_PULSE = 3'b100
   } wd_state_t;

endpackage : recovery_timer_pkg

// File: core/mc_tick_divider.sv
// Machine-cycle enable pulse divider
`timescale 1ns/10ps
module mc_tick_divider #(
   parameter int DIV = 6
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // Control
   input wire logic i_run,
   input wire logic i_clear,
   // Enable pulse
   output logic o_tick
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] ZERO = CW'(0);
   localparam logic [CW-1:0] ONE = CW'(1);

   typedef struct packed {
      logic [CW-1:0] cnt;
   } div_state_t;

   div_state_t st_q;
   div_state_t st_d;

   // ===========================================================
   // Divider counter, frozen while the oscillator is stopped
   always_comb begin
      st_d = st_q;
      if (i_clear) begin
         st_d.cnt = ZERO;
      end else if (i_run) begin
         st_d.cnt = (st_q.cnt == LAST) ? ZERO : st_q.cnt + ONE;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // One pulse per machine cycle
   assign o_tick = i_run && !i_clear && (st_q.cnt == LAST);

   // ===========================================================
   // Checks
   AST_TICK_SPACED: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      o_tick |=> !o_tick)
      else $error("machine-cycle ticks closer than one cycle");

endmodule : mc_tick_divider

// File: core/key_sequence_detector.sv
// Two-byte key sequence detector for the service register
`timescale 1ns/10ps
module key_sequence_detector (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // Write strobe and data
   input wire logic i_wr,
   input wire logic [7:0] i_data,
   // Sequence complete
   output logic o_done
);
   import recovery_timer_pkg::*;

   typedef struct packed {
      logic armed;
   } key_state_t;

   key_state_t st_q;
   key_state_t st_d;

   // ===========================================================
   // Arm on first byte; any other write disarms
   always_comb begin
      st_d = st_q;
      if (i_wr) begin
         st_d.armed = (i_data == KEY_FIRST);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Second byte counts only right after the first
   assign o_done = i_wr && st_q.armed && (i_data == KEY_SECOND);

   // ===========================================================
   // Checks
   sequence s_bad_write;
      i_wr && (i_data != KEY_FIRST);
   endsequence

   AST_ABORT_DISARMS: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      s_bad_write |=> !o_done)
      else $error("key sequence completed after a stray write");

   AST_PAIR_DONE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_wr && i_data == KEY_FIRST) ##1 (i_wr && i_data == KEY_SECOND)
      |-> o_done)
      else $error("ordered key pair not recognised");

endmodule : key_sequence_detector

// File: verification/recovery_timer_bench.sv
// Self-checking bench for the recovery timer
`timescale 1ns/10ps
// ===========================================================
// Compare helper
`define CHK(got, exp, msg) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("wrong value at %0t ns: %s", $time, msg); \
      end \
   end
module recovery_timer_bench;
   import recovery_timer_pkg::*;
   // ========================================================
   // Signals
   logic i_sys_clk;
   logic i_nrst;
   logic [7:0] i_sfr_addr;
   logic [7:0] i_sfr_wdata;
   logic i_sfr_wr;
   logic i_sfr_rd;
   logic [7:0] o_sfr_rdata;
   logic i_power_down;
   logic i_idle;
   logic i_wake_int_n;
   logic o_rst_out;
   logic o_rst_oe;
   logic o_running;
   logic [SEL_W-1:0] o_timeout_sel;
   int miscompares = 0;
   int samples_checked = 0;
   int seed = 38;
   int cyc = 0;
   int hi_cnt = 0;
   logic rd_d1 = 1'b0;
   logic rst_d1 = 1'b0;
   logic [13:0] rd_q[$];
   logic [13:0] obs;
   int pulse_q[$];
   localparam logic [7:0] UNMAPPED = 8'h3c;

   recovery_timer dut (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
      .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
      .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
      .o_sfr_rdata(o_sfr_rdata), .i_power_down(i_power_down),
      .i_idle(i_idle), .i_wake_int_n(i_wake_int_n),
      .o_rst_out(o_rst_out), .o_rst_oe(o_rst_oe),
      .o_running(o_running), .o_timeout_sel(o_timeout_sel)
   );

   // Status and read data as one observed word
   assign obs = {o_running, o_rst_out, o_rst_oe, o_timeout_sel, o_sfr_rdata};

   // 40 MHz clock
   initial begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   // ========================================================
   // Monitor: read answers and reset-pulse width
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      rd_d1 <= i_sfr_rd;
      rst_d1 <= o_rst_out;
      if (rd_d1 && rd_q.size() > 0) begin
         `CHK(obs, rd_q.pop_front(), "observed state")
      end
      // Out and enable must be high together to count
      if (o_rst_out && o_rst_oe) begin
         hi_cnt <= hi_cnt + 1;
      end
      if (rst_d1 && !o_rst_out && pulse_q.size() > 0) begin
         `CHK(hi_cnt, pulse_q.pop_front(), "reset pulse width")
         hi_cnt <= 0;
      end
   end

   // ========================================================
   // Drivers; strobes stay up between back-to-back accesses
   task automatic sfr(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      i_sfr_wr = w;
      i_sfr_rd = !w;
      i_sfr_addr = a;
      i_sfr_wdata = d;
      @(negedge i_sys_clk);
   endtask : sfr

   task automatic idle(input int n);
      i_sfr_wr = 1'b0;
      i_sfr_rd = 1'b0;
      repeat (n) @(negedge i_sys_clk);
   endtask : idle

   // Read with expected data and status noted for the monitor
   task automatic chk_rd(input logic [7:0] a, input logic run,
                         input logic [2:0] sel, input logic [7:0] d);
      rd_q.push_back({run, 1'b0, 1'b0, sel, d});
      sfr(1'b0, a, 8'h00);
   endtask : chk_rd

   // Random service-register byte that never arms the detector
   function automatic logic [7:0] junk();
      logic [7:0] v;
      v = KEY_FIRST;
      while (v == KEY_FIRST || v == KEY_SECOND) begin
         v = 8'($random(seed));
      end
      return v;
   endfunction : junk

   task automatic results;
      $display("checks %0d, mismatches %0d", samples_checked,
               miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   // Hang guard, longer than the full overflow test
   initial begin
      repeat (120000) @(posedge i_sys_clk);
      miscompares++;
      $display("wrong value at %0t ns: run did not finish", $time);
      results();
   end

   // ========================================================
   // Main sequence
   initial begin
      int svc;
      int w;
      int exp_t;
      int dt;
      logic in_win;
      i_nrst = 1'b0;
      i_sfr_wr = 1'b0;
      i_sfr_rd = 1'b0;
      i_sfr_addr = 8'h00;
      i_sfr_wdata = 8'h00;
      i_power_down = 1'b0;
      i_idle = 1'b0;
      i_wake_int_n = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      i_nrst = 1'b1;
      chk_rd(TIMEOUT_ADDR, 1'b0, 3'h0, 8'h00);
      chk_rd(SERVICE_ADDR, 1'b0, 3'h0, 8'h00);
      chk_rd(UNMAPPED, 1'b0, 3'h0, 8'h00);
      $display("reset state test done");
      // Every select code, read back with reserved bits clear
      for (int n = 0; n < 8; n++) begin
         sfr(1'b1, TIMEOUT_ADDR, {5'h00, 3'(n)});
         chk_rd(TIMEOUT_ADDR, 1'b0, 3'(n), {5'h00, 3'(n)});
      end
      $display("select code test done");
      // Stray byte between keys, then a lone second key
      sfr(1'b1, SERVICE_ADDR, KEY_FIRST);
      sfr(1'b1, SERVICE_ADDR, junk());
      sfr(1'b1, SERVICE_ADDR, KEY_SECOND);
      sfr(1'b1, SERVICE_ADDR, KEY_SECOND);
      idle(2);
      chk_rd(TIMEOUT_ADDR, 1'b0, 3'h7, 8'h07);
      $display("aborted sequence test done");
      // Enable with another register written between the keys
      sfr(1'b1, SERVICE_ADDR, KEY_FIRST);
      sfr(1'b1, TIMEOUT_ADDR, 8'h00);
      sfr(1'b1, SERVICE_ADDR, KEY_SECOND);
      idle(2);
      chk_rd(TIMEOUT_ADDR, 1'b1, 3'h0, 8'h00);
      // Software cannot stop it
      for (int n = 0; n < 6; n++) begin
         sfr(1'b1, SERVICE_ADDR, junk());
      end
      idle(2);
      chk_rd(SERVICE_ADDR, 1'b1, 3'h0, 8'h00);
      $display("enable test done");
      // Service after a random delay, then let it overflow
      idle(100 + ($random(seed) & 32'h3ff));
      sfr(1'b1, SERVICE_ADDR, KEY_FIRST);
      sfr(1'b1, SERVICE_ADDR, KEY_SECOND);
      svc = cyc;
      idle(1000);
      // Idle must not stop the count; power-down and wake do
      i_idle = 1'b1;
      idle(2000);
      i_idle = 1'b0;
      i_power_down = 1'b1;
      idle(200);
      i_power_down = 1'b0;
      i_wake_int_n = 1'b0;
      idle(100);
      i_wake_int_n = 1'b1;
      pulse_q.push_back(PULSE_CYCLES);
      w = 0;
      while (w < 100000 && o_rst_out !== 1'b1) begin
         @(negedge i_sys_clk);
         w++;
      end
      // Divider phase is hidden, so allow a few clocks of slack
      exp_t = MACHINE_CYCLE_CLOCKS * (1 << BASE_W) + 300;
      dt = cyc - svc;
      in_win = (dt > exp_t - 8) && (dt < exp_t + 8);
      `CHK(in_win, 1'b1, "overflow time")
      `CHK(o_rst_oe, 1'b1, "reset pin enable")
      w = 0;
      while (w < 200 && o_rst_out !== 1'b0) begin
         @(negedge i_sys_clk);
         w++;
      end
      idle(2);
      chk_rd(TIMEOUT_ADDR, 1'b0, 3'h0, 8'h00);
      idle(2);
      $display("overflow test done");
      results();
   end
endmodule : recovery_timer_bench
